//--- core/rimc_pkg.sv
// Constants, types and register map for the reference input config/monitor block.
// Assumes a 100 MHz system clock and word-aligned AHB-Lite register access.
package rimc_pkg;

	// System clock and millisecond timebase
	localparam int     CLK_PERIOD_NS = 10;
	localparam int     MS_TIME_NS    = 1_000_000;
	localparam int     MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
	localparam longint SYS_PERIOD_FS = longint'(CLK_PERIOD_NS) * 1_000_000;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_RX_TYPE  = 12'h300;
	localparam logic [11:0] IDX_PDIV_LO  = 12'h301;
	localparam logic [11:0] IDX_PDIV_MID = 12'h302;
	localparam logic [11:0] IDX_PDIV_HI  = 12'h303;
	localparam logic [11:0] IDX_PER_B0   = 12'h304;
	localparam logic [11:0] IDX_PER_B1   = 12'h305;
	localparam logic [11:0] IDX_PER_B2   = 12'h306;
	localparam logic [11:0] IDX_PER_B3   = 12'h307;
	localparam logic [11:0] IDX_PER_B4   = 12'h308;
	localparam logic [11:0] IDX_INN_LO   = 12'h309;
	localparam logic [11:0] IDX_INN_MID  = 12'h30A;
	localparam logic [11:0] IDX_INN_HI   = 12'h30B;
	localparam logic [11:0] IDX_OUT_LO   = 12'h30C;
	localparam logic [11:0] IDX_OUT_MID  = 12'h30D;
	localparam logic [11:0] IDX_OUT_HI   = 12'h30E;
	localparam logic [11:0] IDX_VAL_LO   = 12'h30F;
	localparam logic [11:0] IDX_VAL_HI   = 12'h310;
	localparam logic [11:0] IDX_LIVE     = 12'h3F0;
	localparam logic [11:0] IDX_EVENT    = 12'h3F1;
	localparam logic [11:0] IDX_MASK     = 12'h3F2;

	// Values after reset
	localparam logic [19:0] RST_PDIV     = 20'h0_0000;
	localparam logic [39:0] RST_PERIOD   = 40'h00_0000_0000;
	localparam logic [19:0] RST_INNER    = 20'h0_0014;
	localparam logic [19:0] RST_OUTER    = 20'h0_000A;
	localparam logic [15:0] RST_VAL_TIME = 16'h000A;
	localparam logic [3:0]  RST_MASK     = 4'h0;

	// Event bit positions in the event and mask registers
	localparam int EV_FAULT_SET = 0;
	localparam int EV_FAULT_CLR = 1;
	localparam int EV_VALID_SET = 2;
	localparam int EV_VALID_CLR = 3;
	localparam int EV_W         = 4;

	// Receiver logic family
	typedef enum logic [1:0] {
		RX_CMOS    = 2'b00,
		RX_AC_DIFF = 2'b01,
		RX_DC_LVDS = 2'b10,
		RX_UNUSED  = 2'b11
	} rimc_rx_t;

	// Qualification state of the reference
	typedef enum logic [1:0] {
		MON_FAULT   = 2'b00,
		MON_QUALIFY = 2'b01,
		MON_VALID   = 2'b10
	} rimc_mon_t;

	// Software configuration of the input
	typedef struct packed {
		rimc_rx_t    rx_type;
		logic [19:0] prediv;
		logic [39:0] period;
		logic [19:0] inner;
		logic [19:0] outer;
		logic [15:0] val_time;
	} rimc_cfg_t;

endpackage

//--- core/rimc_top.sv
// Reference input configuration registers and frequency/validation monitor.
// Assumes one AHB-Lite master on clk_sys and an asynchronous reference pin pair.
//
// Summary of operation
// - Two-bit field selects receiver logic family.
// - CMOS mode uses only the true pin.
// - Twenty-bit pre-divider divides by value plus one.
// - Pre-divider resets to zero, ratio one.
// - Forty-bit nominal period, femtoseconds, resets zero.
// - Inner tolerance resets to twenty, five percent.
// - Outer tolerance resets to ten, ten percent.
// - Valid only after unfaulted validation time.
`timescale 1ns/1ps
module rimc_top
	import rimc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter int MEAS_W    = 32
)
(
	// Clock and reset
	input  logic        clk_sys,
	input  logic        rst,
	// AHB-Lite slave
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	// Reference pin pair
	input  logic        ref_p,
	input  logic        ref_n,
	// Towards receiver and loop
	output logic [1:0]  rx_mode,
	output logic        ref_div_pulse,
	output logic        ref_fault,
	output logic        ref_valid,
	// Interrupt
	output logic        irq
);

	// Refuse settings the counters cannot serve
	if (MS_CYCLES < 1) $error("MS_CYCLES must be at least one");
	if (MEAS_W < 8 || MEAS_W > 40) $error("MEAS_W must be 8 to 40");

	// Scaled tolerance check: err * tol above expected
	function automatic logic tol_exceeded(input logic [63:0] err,
		input logic [19:0] tol, input logic [63:0] expd);
		logic [83:0] prod;
		prod = 84'(err) * 84'(tol);
		return prod > 84'(expd);
	endfunction

	// Bus state
	logic        hreadyout_reg;    // Low for the single read wait state
	logic        hresp_reg;        // Always OKAY
	logic [31:0] hrdata_reg;       // Read data, held until next read
	logic        rd_pend_reg;      // Read address phase taken
	logic [11:0] rd_idx_reg;       // Its register index
	logic        wr_pend_reg;      // Write data phase now
	logic [11:0] wr_idx_reg;       // Its register index
	logic        acc;              // Address phase accepted
	logic        cfg_wr;           // Write landing on a config register
	logic [7:0]  rd_byte;          // Read mux result

	// Configuration and event registers
	rimc_cfg_t   cfg_reg;
	logic [EV_W-1:0] status_reg;   // Sticky events
	logic [EV_W-1:0] status_next;
	logic [EV_W-1:0] mask_reg;     // Interrupt enables
	logic [EV_W-1:0] ev;           // Event pulses this cycle
	logic        irq_reg;

	// Reference input path
	logic        p_s1_reg;         // First stages feed only second stages
	logic        p_s2_reg;
	logic        n_s1_reg;
	logic        n_s2_reg;
	logic        ref_lvl_reg;      // Receiver output level
	logic        ref_prev_reg;
	logic        ref_rise;
	logic [19:0] div_cnt_reg;      // Edges since last divided pulse
	logic        div_tick_reg;

	// Monitor
	logic [MEAS_W-1:0] per_cnt_reg; // Clocks since last divided pulse
	logic        armed_reg;        // A previous divided pulse exists
	logic        timeout;
	logic        bad_cfg;
	logic        judge;
	logic [63:0] meas_fs;
	logic [63:0] exp_fs;
	logic [63:0] err_fs;
	logic        outer_bad;
	logic        inner_ok;
	logic        fault_reg;
	logic        fault_d_reg;
	rimc_mon_t   state_reg;
	rimc_mon_t   state_next;
	logic        valid_reg;
	logic [16:0] ms_cnt_reg;       // Whole milliseconds unfaulted
	logic [31:0] ms_div_reg;       // Clocks within the current millisecond
	logic        ms_tick;

	// Address phase decode; only word transfers are expected
	assign acc    = hsel && htrans[1] && hready;
	assign cfg_wr = wr_pend_reg && (wr_idx_reg >= IDX_RX_TYPE) && (wr_idx_reg <= IDX_VAL_HI);

	// Bus handshake: writes zero-wait, reads take one wait state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
			rd_pend_reg   <= 1'b0;
			rd_idx_reg    <= 12'h000;
			wr_pend_reg   <= 1'b0;
			wr_idx_reg    <= 12'h000;
		end
		else
		begin
			hreadyout_reg <= !(acc && !hwrite);
			hresp_reg     <= 1'b0;
			rd_pend_reg   <= acc && !hwrite;
			wr_pend_reg   <= acc && hwrite;
			// Index from word address; low address bits ignored
			if (acc)
			begin
				rd_idx_reg <= haddr[13:2];
				wr_idx_reg <= haddr[13:2];
			end
		end
	end

	// Read mux; reserved bits and unmapped indices read zero
	always_comb
	begin
		rd_byte = 8'h00;
		case (rd_idx_reg)
			IDX_RX_TYPE:  rd_byte = {6'h00, cfg_reg.rx_type};
			IDX_PDIV_LO:  rd_byte = cfg_reg.prediv[7:0];
			IDX_PDIV_MID: rd_byte = cfg_reg.prediv[15:8];
			IDX_PDIV_HI:  rd_byte = {4'h0, cfg_reg.prediv[19:16]};
			IDX_PER_B0:   rd_byte = cfg_reg.period[7:0];
			IDX_PER_B1:   rd_byte = cfg_reg.period[15:8];
			IDX_PER_B2:   rd_byte = cfg_reg.period[23:16];
			IDX_PER_B3:   rd_byte = cfg_reg.period[31:24];
			IDX_PER_B4:   rd_byte = cfg_reg.period[39:32];
			IDX_INN_LO:   rd_byte = cfg_reg.inner[7:0];
			IDX_INN_MID:  rd_byte = cfg_reg.inner[15:8];
			IDX_INN_HI:   rd_byte = {4'h0, cfg_reg.inner[19:16]};
			IDX_OUT_LO:   rd_byte = cfg_reg.outer[7:0];
			IDX_OUT_MID:  rd_byte = cfg_reg.outer[15:8];
			IDX_OUT_HI:   rd_byte = {4'h0, cfg_reg.outer[19:16]};
			IDX_VAL_LO:   rd_byte = cfg_reg.val_time[7:0];
			IDX_VAL_HI:   rd_byte = cfg_reg.val_time[15:8];
			IDX_LIVE:     rd_byte = {4'h0, state_reg, ref_lvl_reg, fault_reg};
			IDX_EVENT:    rd_byte = {4'h0, status_reg};
			IDX_MASK:     rd_byte = {4'h0, mask_reg};
			default:      rd_byte = 8'h00;
		endcase
	end

	// Read data loaded in the wait state, after any prior write landed
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			hrdata_reg <= 32'h0000_0000;
		else if (rd_pend_reg)
			hrdata_reg <= {24'h00_0000, rd_byte};
	end

	// Configuration writes in the data phase, low byte lane only
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cfg_reg.rx_type  <= RX_CMOS;
			cfg_reg.prediv   <= RST_PDIV;
			cfg_reg.period   <= RST_PERIOD;
			cfg_reg.inner    <= RST_INNER;
			cfg_reg.outer    <= RST_OUTER;
			cfg_reg.val_time <= RST_VAL_TIME;
			mask_reg         <= RST_MASK;
		end
		else if (wr_pend_reg)
		begin
			case (wr_idx_reg)
				IDX_RX_TYPE:  cfg_reg.rx_type         <= rimc_rx_t'(hwdata[1:0]);
				IDX_PDIV_LO:  cfg_reg.prediv[7:0]     <= hwdata[7:0];
				IDX_PDIV_MID: cfg_reg.prediv[15:8]    <= hwdata[7:0];
				IDX_PDIV_HI:  cfg_reg.prediv[19:16]   <= hwdata[3:0];
				IDX_PER_B0:   cfg_reg.period[7:0]     <= hwdata[7:0];
				IDX_PER_B1:   cfg_reg.period[15:8]    <= hwdata[7:0];
				IDX_PER_B2:   cfg_reg.period[23:16]   <= hwdata[7:0];
				IDX_PER_B3:   cfg_reg.period[31:24]   <= hwdata[7:0];
				IDX_PER_B4:   cfg_reg.period[39:32]   <= hwdata[7:0];
				IDX_INN_LO:   cfg_reg.inner[7:0]      <= hwdata[7:0];
				IDX_INN_MID:  cfg_reg.inner[15:8]     <= hwdata[7:0];
				IDX_INN_HI:   cfg_reg.inner[19:16]    <= hwdata[3:0];
				IDX_OUT_LO:   cfg_reg.outer[7:0]      <= hwdata[7:0];
				IDX_OUT_MID:  cfg_reg.outer[15:8]     <= hwdata[7:0];
				IDX_OUT_HI:   cfg_reg.outer[19:16]    <= hwdata[3:0];
				IDX_VAL_LO:   cfg_reg.val_time[7:0]   <= hwdata[7:0];
				IDX_VAL_HI:   cfg_reg.val_time[15:8]  <= hwdata[7:0];
				IDX_MASK:     mask_reg                <= hwdata[EV_W-1:0];
				default:      ;
			endcase
		end
	end

	// Pin synchronisers, two stages each
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			p_s1_reg <= 1'b0;
			p_s2_reg <= 1'b0;
			n_s1_reg <= 1'b0;
			n_s2_reg <= 1'b0;
		end
		else
		begin
			p_s1_reg <= ref_p;
			p_s2_reg <= p_s1_reg;
			n_s1_reg <= ref_n;
			n_s2_reg <= n_s1_reg;
		end
	end

	// Receiver: CMOS ignores the complement pin; differential needs both to disagree
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ref_lvl_reg  <= 1'b0;
			ref_prev_reg <= 1'b0;
		end
		else
		begin
			ref_prev_reg <= ref_lvl_reg;
			unique case (cfg_reg.rx_type)
				RX_CMOS:    ref_lvl_reg <= p_s2_reg;
				RX_AC_DIFF,
				RX_DC_LVDS:
				begin
					// Equal levels are a crossing in progress; hold the last state
					if (p_s2_reg != n_s2_reg)
						ref_lvl_reg <= p_s2_reg;
				end
				RX_UNUSED:  ref_lvl_reg <= 1'b0;
			endcase
		end
	end

	assign ref_rise = ref_lvl_reg && !ref_prev_reg;

	// Pre-divider: one pulse per stored value plus one rising edges
	always_ff @(posedge clk_sys)
	begin
		if (rst || cfg_wr)
		begin
			div_cnt_reg  <= 20'h0_0000;
			div_tick_reg <= 1'b0;
		end
		else
		begin
			div_tick_reg <= 1'b0;
			if (ref_rise)
			begin
				if (div_cnt_reg == cfg_reg.prediv)
				begin
					div_cnt_reg  <= 20'h0_0000;
					div_tick_reg <= 1'b1;
				end
				else
					div_cnt_reg <= div_cnt_reg + 20'h0_0001;
			end
		end
	end

	// Period counter between divided pulses; saturation means a lost reference
	always_ff @(posedge clk_sys)
	begin
		if (rst || cfg_wr)
		begin
			per_cnt_reg <= '0;
			armed_reg   <= 1'b0;
		end
		else if (div_tick_reg)
		begin
			per_cnt_reg <= MEAS_W'(1);
			armed_reg   <= 1'b1;
		end
		else if (!timeout)
			per_cnt_reg <= per_cnt_reg + MEAS_W'(1);
	end

	// Measured against expected divided period, both in femtoseconds
	assign timeout   = &per_cnt_reg;
	assign bad_cfg   = (cfg_reg.period == RST_PERIOD) || (cfg_reg.rx_type == RX_UNUSED);
	assign judge     = div_tick_reg && armed_reg;
	assign meas_fs   = 64'(per_cnt_reg) * 64'(SYS_PERIOD_FS);
	assign exp_fs    = 64'(cfg_reg.period) * (64'(cfg_reg.prediv) + 64'h0000_0001);
	assign err_fs    = (meas_fs > exp_fs) ? meas_fs - exp_fs : exp_fs - meas_fs;
	assign outer_bad = tol_exceeded(err_fs, cfg_reg.outer, exp_fs);
	assign inner_ok  = !tol_exceeded(err_fs, cfg_reg.inner, exp_fs);

	// Fault flag with hysteresis; a config write restarts qualification
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			fault_reg   <= 1'b1;
			fault_d_reg <= 1'b1;
		end
		else
		begin
			fault_d_reg <= fault_reg;
			if (cfg_wr || timeout || bad_cfg)
				fault_reg <= 1'b1;
			else if (judge)
			begin
				// Between the two limits the flag keeps its state
				if (outer_bad)
					fault_reg <= 1'b1;
				else if (inner_ok)
					fault_reg <= 1'b0;
			end
		end
	end

	// Qualification sequence
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			MON_FAULT:
				if (!fault_reg)
					state_next = MON_QUALIFY;
			MON_QUALIFY:
				if (fault_reg)
					state_next = MON_FAULT;
				else if (ms_cnt_reg >= 17'(cfg_reg.val_time))
					state_next = MON_VALID;
			MON_VALID:
				if (fault_reg)
					state_next = MON_FAULT;
			default:
				state_next = MON_FAULT;
		endcase
	end

	// State and valid flag
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg <= MON_FAULT;
			valid_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			valid_reg <= (state_next == MON_VALID);
		end
	end

	// Millisecond divider restarts with qualification so the wait is never short
	assign ms_tick = (ms_div_reg == 32'(MS_CYCLES - 1));

	always_ff @(posedge clk_sys)
	begin
		if (rst || state_reg != MON_QUALIFY)
		begin
			ms_div_reg <= 32'h0000_0000;
			ms_cnt_reg <= 17'h0_0000;
		end
		else if (ms_tick)
		begin
			ms_div_reg <= 32'h0000_0000;
			if (ms_cnt_reg != 17'h1_FFFF)
				ms_cnt_reg <= ms_cnt_reg + 17'h0_0001;
		end
		else
			ms_div_reg <= ms_div_reg + 32'h0000_0001;
	end

	// Event pulses from flag edges
	assign ev[EV_FAULT_SET] = fault_reg && !fault_d_reg;
	assign ev[EV_FAULT_CLR] = !fault_reg && fault_d_reg;
	assign ev[EV_VALID_SET] = (state_next == MON_VALID) && !valid_reg;
	assign ev[EV_VALID_CLR] = (state_next != MON_VALID) && valid_reg;

	// Sticky status, write one to clear; a new event wins over the clear
	always_comb
	begin
		status_next = status_reg;
		if (wr_pend_reg && wr_idx_reg == IDX_EVENT)
			status_next = status_next & ~hwdata[EV_W-1:0];
		status_next = status_next | ev;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			status_reg <= '0;
			irq_reg    <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			irq_reg    <= |(status_reg & mask_reg);
		end
	end

	// Outputs, all from flip-flops
	assign hreadyout     = hreadyout_reg;
	assign hresp         = hresp_reg;
	assign hrdata        = hrdata_reg;
	assign rx_mode       = cfg_reg.rx_type;
	assign ref_div_pulse = div_tick_reg;
	assign ref_fault     = fault_reg;
	assign ref_valid     = valid_reg;
	assign irq           = irq_reg;

	// Checks
	chk_rx_mode_map: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_pend_reg && wr_idx_reg == IDX_RX_TYPE) |=> rx_mode == $past(hwdata[1:0]))
		else $error("receiver mode not taken from write");
	chk_cmos_true_pin: assert property (@(posedge clk_sys) disable iff (rst)
		($past(cfg_reg.rx_type) == RX_CMOS) |-> ref_lvl_reg == $past(p_s2_reg))
		else $error("cmos level not following true pin");
	chk_div_ratio: assert property (@(posedge clk_sys) disable iff (rst)
		div_tick_reg |-> $past(ref_rise) && $past(div_cnt_reg) == $past(cfg_reg.prediv))
		else $error("divided pulse at wrong edge count");
	chk_div_unity: assert property (@(posedge clk_sys) disable iff (rst)
		(ref_rise && cfg_reg.prediv == 20'h0_0000 && !cfg_wr) |=> div_tick_reg)
		else $error("zero divider not passing every edge");
	chk_cfg_reset: assert property (@(posedge clk_sys) disable iff (rst)
		$past(rst) |-> cfg_reg.prediv == RST_PDIV && cfg_reg.period == RST_PERIOD
			&& cfg_reg.inner == RST_INNER && cfg_reg.outer == RST_OUTER)
		else $error("configuration reset value wrong");
	chk_valid_wait: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(valid_reg) |-> $past(state_reg) == MON_QUALIFY
			&& $past(ms_cnt_reg) >= 17'($past(cfg_reg.val_time)))
		else $error("valid before validation time");
	chk_fault_drops: assert property (@(posedge clk_sys) disable iff (rst)
		fault_reg |=> !valid_reg)
		else $error("valid while faulted");
	chk_outer_trip: assert property (@(posedge clk_sys) disable iff (rst)
		(judge && outer_bad) |=> fault_reg)
		else $error("fault not raised beyond outer limit");
	chk_inner_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(fault_reg && judge && !inner_ok) |=> fault_reg)
		else $error("fault cleared outside inner limit");
	chk_read_wait: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	// Sampled reset in the antecedent keeps a reset cycle out of the comparison
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
		!rst |=> irq == $past(|(status_reg & mask_reg)))
		else $error("interrupt level wrong");

endmodule

//--- tb/rimc_ref_src.sv
// Behavioural reference clock source standing on the far side of the input pins.
// Assumes half periods of 20 ns or more, so each level lasts two clk_sys cycles at least.
`timescale 1ns/1ps
module rimc_ref_src
(
	// Control from the bench
	input  int   half_ns,
	input  logic comp_stuck,
	// Reference pin pair
	output logic ref_p,
	output logic ref_n,
	// Rising edges sent so far
	output int   edges
);
	// Free running; odd start offset keeps it unrelated in phase to clk_sys
	initial
	begin
		ref_p = 1'b0;
		edges = 0;
		#3.3;
		forever
		begin
			#(half_ns);
			ref_p = ~ref_p;
			if (ref_p)
				edges++;
		end
	end
	// Complement tracks the true pin unless a broken pair is wanted
	assign ref_n = comp_stuck ? 1'b0 : ~ref_p;
endmodule

//--- tb/test_reference_input_config_monitor.sv
// Self-checking bench for the reference input configuration and monitor block.
// Assumes the reference source model and a short millisecond count for simulation.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_reference_input_config_monitor;
	import rimc_pkg::*;
	localparam int MS_SIM = 20; // Clocks per ms, shortened
	typedef struct packed {logic [11:0] idx; logic [7:0] wd; logic [7:0] rv; logic [7:0] rd;} rimc_row_t;
	logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, comp_stuck;
	logic        ref_p, ref_n, ref_div_pulse, ref_fault, ref_valid, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, rx_mode;
	logic [2:0]  hsize;
	int          half_ns, edges, pulses, error_cnt, checks_done, n, p0;
	// Rows: index, write value, reset value, read-back value
	rimc_row_t   rows [18] = '{
		'{IDX_RX_TYPE,  8'hFC, 8'h00, 8'h00}, // Reserved bits dropped, CMOS left
		'{IDX_PDIV_LO,  8'h09, 8'h00, 8'h09}, // Divide by ten
		'{IDX_PDIV_MID, 8'h00, 8'h00, 8'h00},
		'{IDX_PDIV_HI,  8'hF0, 8'h00, 8'h00}, // Only four bits held
		'{IDX_PER_B0,   8'h00, 8'h00, 8'h00}, // 80 ns in fs, low byte first
		'{IDX_PER_B1,   8'hB4, 8'h00, 8'hB4},
		'{IDX_PER_B2,   8'hC4, 8'h00, 8'hC4},
		'{IDX_PER_B3,   8'h04, 8'h00, 8'h04},
		'{IDX_PER_B4,   8'h00, 8'h00, 8'h00},
		'{IDX_INN_LO,   8'h14, 8'h14, 8'h14}, // Inner five percent, in range
		'{IDX_INN_MID,  8'h00, 8'h00, 8'h00},
		'{IDX_INN_HI,   8'hF0, 8'h00, 8'h00},
		'{IDX_OUT_LO,   8'h0A, 8'h0A, 8'h0A}, // Outer ten percent, wider
		'{IDX_OUT_MID,  8'h00, 8'h00, 8'h00},
		'{IDX_OUT_HI,   8'hF0, 8'h00, 8'h00},
		'{IDX_VAL_LO,   8'h02, 8'h0A, 8'h02}, // Two ms validation
		'{IDX_VAL_HI,   8'h00, 8'h00, 8'h00},
		'{12'h3FF,      8'hFF, 8'h00, 8'h00}}; // Unmapped place reads zero
	logic [1:0]  md [4] = '{2'b00, 2'b01, 2'b11, 2'b10}; // Receiver codes to visit
	logic        stk [4] = '{1'b1, 1'b1, 1'b1, 1'b0}; // Complement pin broken
	logic        run [4] = '{1'b1, 1'b0, 1'b0, 1'b1}; // Divided pulses expected

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	rimc_top #(.MS_CYCLES(MS_SIM)) uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ref_p(ref_p), .ref_n(ref_n), .rx_mode(rx_mode), .ref_div_pulse(ref_div_pulse),
		.ref_fault(ref_fault), .ref_valid(ref_valid), .irq(irq));
	rimc_ref_src src (.half_ns(half_ns), .comp_stuck(comp_stuck), .ref_p(ref_p),
		.ref_n(ref_n), .edges(edges));

	// 100 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Divided pulse tally
	always @(posedge clk_sys)
		if (ref_div_pulse === 1'b1)
			pulses++;

	// One single AHB-Lite transfer; address phase held until ready, then data phase
	task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
		haddr <= {18'h0_0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		hsel <= 1'b1;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, wd};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	// Skip to the cycle after the n-th divided pulse
	task automatic wait_pulses(input int k);
		repeat (k)
		begin
			@(posedge clk_sys);
			while (ref_div_pulse !== 1'b1) @(posedge clk_sys);
		end
	endtask
	// Bounded wait for a fault level
	task automatic wait_fault(input logic v);
		n = 0;
		while (ref_fault !== v && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	// New source rate, then fault and valid after it has settled
	task automatic hyst(input int h, input logic [1:0] ex);
		half_ns = h;
		wait_pulses(6);
		repeat (2) @(posedge clk_sys);
		`CHK("fault_valid", ex, {ref_fault, ref_valid})
	endtask
	// Reference edges between pulses must equal the divide ratio
	task automatic ratio(input int r);
		wait_pulses(1);
		p0 = edges;
		wait_pulses(3);
		`CHK("edges", 3 * r, edges - p0)
	endtask
	// Twenty-bit field written low byte first over three places
	task automatic wr20(input logic [11:0] idx, input logic [19:0] v);
		bus(idx, 1'b1, v[7:0]);
		bus(idx + 12'h001, 1'b1, v[15:8]);
		bus(idx + 12'h002, 1'b1, {4'h0, v[19:16]});
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog against a hang
	initial
	begin
		#400_000;
		error_cnt++;
		give_verdict;
	end

	// Main sequence
	initial
	begin
		{rst, hsel, hwrite, comp_stuck} = 4'b1000;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
		{half_ns, pulses, error_cnt, checks_done} = {32'd40, 96'd0};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CHK("reset_outs", 5'b10000, {ref_fault, rx_mode, ref_valid, irq})
		// Reset value, write, read back for every config place and one unmapped place
		foreach (rows[i])
		begin
			bus(rows[i].idx, 1'b0, 8'h00);
			`CHK("reset_value", {24'h00_0000, rows[i].rv}, rd)
			bus(rows[i].idx, 1'b1, rows[i].wd);
			bus(rows[i].idx, 1'b0, 8'h00);
			`CHK("read_back", {24'h00_0000, rows[i].rd}, rd)
		end
		// Nominal source: fault clears, valid after two ms unfaulted
		wait_fault(1'b0);
		`CHK("fault_clear", 1'b0, ref_fault)
		n = 0;
		while (ref_valid !== 1'b1 && n < 500)
		begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("valid_delay", 1'b1, (n >= 2 * MS_SIM - 2 && n <= 2 * MS_SIM + 4))
		// 7.5 % sits between the limits, 25 % is beyond the outer one
		hyst(43, 2'b01);
		hyst(50, 2'b10);
		hyst(43, 2'b10);
		hyst(40, 2'b01);
		// All four events seen; masked, so no interrupt yet
		bus(IDX_EVENT, 1'b0, 8'h00);
		`CHK("events", 32'h0000_000F, rd)
		`CHK("irq_masked", 1'b0, irq)
		bus(IDX_MASK, 1'b1, 8'h02);
		repeat (2) @(posedge clk_sys);
		`CHK("irq_on", 1'b1, irq)
		bus(IDX_EVENT, 1'b1, 8'h02);
		repeat (2) @(posedge clk_sys);
		`CHK("irq_off", 1'b0, irq)
		bus(IDX_EVENT, 1'b0, 8'h00);
		`CHK("events_w1c", 32'h0000_000D, rd)
		// Divide ratios ten and one
		ratio(10);
		bus(IDX_PDIV_LO, 1'b1, 8'h00);
		ratio(1);
		// Recommended tight limits: Stratum 3 pair, then the SMC outer limit
		// Divide by ten again so one clock of quantisation stays far below 7.5 %
		bus(IDX_PDIV_LO, 1'b1, 8'h09);
		wr20(IDX_INN_LO, 20'h1_A898);
		wr20(IDX_OUT_LO, 20'h1_4585);
		wait_fault(1'b0);
		`CHK("tight_clear", 1'b0, ref_fault)
		hyst(43, 2'b10);
		wr20(IDX_OUT_LO, 20'h0_5161);
		hyst(40, 2'b01);
		// Receiver codes, some with a broken complement pin
		for (int i = 0; i < 4; i++)
		begin
			comp_stuck = stk[i];
			bus(IDX_RX_TYPE, 1'b1, {6'h00, md[i]});
			repeat (20) @(posedge clk_sys);
			p0 = pulses;
			repeat (200) @(posedge clk_sys);
			`CHK("rx_mode", md[i], rx_mode)
			`CHK("mode_pulses", run[i], pulses != p0)
		end
		// Second reset in mid-run
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CHK("rerun_outs", 5'b10000, {ref_fault, rx_mode, ref_valid, irq})
		bus(IDX_RX_TYPE, 1'b0, 8'h00);
		`CHK("rerun_type", 32'h0000_0000, rd)
		give_verdict;
	end
endmodule
